/* File: core_ops.v */
// execution of call, watchdog kick, clears, invert and decrement
// Contract
// (RULE_01) call pushes pc plus one, two cycles
// (RULE_02) call loads eleven-bit target into pc low
// (RULE_03) pc bits 12:11 from latch bits 4:3
// (RULE_04) watchdog kick zeroes watchdog counter
// (RULE_05) watchdog kick also clears its prescaler
// (RULE_06) watchdog kick sets time-out and sleep flags
// (RULE_07) file clear writes zero, sets zero flag
// (RULE_08) invert file reg, destination bit selects target
// (RULE_09) accumulator clear writes zero, sets zero flag
// (RULE_10) decrement file reg, destination bit selects target
// (RULE_11) invert/decrement set zero flag from result
// (RULE_12) others one cycle, keep time-out and sleep
`timescale 1ns/1ns
`include "core_ops_defs.vh"
module core_ops #(
  parameter DW = 8,
  parameter AW = 7,
  parameter WDT_W = 8,
  parameter PRESC_W = 8
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_op_valid,
  input wire [2:0] i_op_code,
  input wire [`PC_LO_W-1:0] i_call_target,
  input wire [AW-1:0] i_file_addr,
  input wire i_dest_file,
  input wire [DW-1:0] i_file_rdata,
  input wire [DW-1:0] i_pc_high_latch,
  input wire i_watchdog_tick,
  input wire i_prescale_tick,
  input wire i_flags_clear,
  output wire o_op_ready,
  output reg o_op_done,
  output reg [`PC_W-1:0] o_program_counter,
  output reg o_stack_push,
  output reg [`PC_W-1:0] o_stack_top_entry,
  output reg o_file_we,
  output reg [AW-1:0] o_file_waddr,
  output reg [DW-1:0] o_file_wdata,
  output reg [DW-1:0] o_accumulator,
  output reg o_zero_flag,
  output reg o_time_out_flag,
  output reg o_sleep_flag,
  output reg [WDT_W-1:0] o_watchdog_counter,
  output reg [PRESC_W-1:0] o_prescaler
);
  ////////////////////////////////////////////////////////////////////////////
  // one-hot states: idle, and the second cycle of a call
  localparam ST_IDLE = 2'h1;
  localparam ST_CALL2 = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [`PC_W-1:0] next_pc;
  reg [DW-1:0] next_acc;
  reg next_zero;
  reg next_time_out;
  reg next_sleep;
  reg [WDT_W-1:0] next_watchdog;
  reg [PRESC_W-1:0] next_prescaler;
  wire [DW-1:0] alu_result;
  wire alu_zero;
  wire take;
  wire is_dec;
  wire do_call;
  wire do_kick;
  wire do_fzero;
  wire do_azero;
  wire do_alu;
  wire file_write;
  wire [DW-1:0] file_value;
  wire [`PC_W-1:0] pc_plus_one;
  wire [`PC_W-1:0] call_dest;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the accepted instruction
  assign o_op_ready = state[0];
  assign take = i_op_valid && o_op_ready;
  assign is_dec = (i_op_code == `OP_DEC);
  assign do_call = take && (i_op_code == `OP_CALL);
  assign do_kick = take && (i_op_code == `OP_KICK);
  assign do_fzero = take && (i_op_code == `OP_FZERO);
  assign do_azero = take && (i_op_code == `OP_AZERO);
  assign do_alu = take && ((i_op_code == `OP_INV) || is_dec);
  assign file_write = do_fzero || (do_alu && i_dest_file); // RULE_07 RULE_08 RULE_10
  assign file_value = do_fzero ? {DW{1'h0}} : alu_result; // RULE_07
  assign pc_plus_one = o_program_counter + `PC_STEP; // RULE_01
  assign call_dest = {i_pc_high_latch[`LATCH_HI_POS:`LATCH_LO_POS], // RULE_03
    i_call_target}; // RULE_02

  // complement or decrement of the addressed file register
  result_unit #(
    .W(DW)
  ) u_result (
    .i_operand(i_file_rdata),
    .i_decrement(is_dec),
    .o_result(alu_result),
    .o_is_zero(alu_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: a call holds the block for one extra cycle
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (do_call) begin
          next_state = ST_CALL2; // RULE_01
        end
      end
      ST_CALL2: begin
        next_state = ST_IDLE; // RULE_01
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // program counter: call target, or step to the next instruction
  always @* begin
    next_pc = o_program_counter;
    if (do_call) begin
      next_pc = call_dest; // RULE_02 RULE_03
    end else if (take) begin
      next_pc = pc_plus_one; // RULE_12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and zero flag
  always @* begin
    next_acc = o_accumulator;
    next_zero = o_zero_flag;
    if (do_fzero) begin
      next_zero = 1'h1; // RULE_07
    end
    if (do_azero) begin
      next_acc = {DW{1'h0}}; // RULE_09
      next_zero = 1'h1; // RULE_09
    end
    if (do_alu) begin
      if (!i_dest_file) begin
        next_acc = alu_result; // RULE_08 RULE_10
      end
      next_zero = alu_zero; // RULE_11
    end
  end

  // time-out and sleep flags: cleared by other core logic, set by a kick
  always @* begin
    next_time_out = o_time_out_flag; // RULE_12
    next_sleep = o_sleep_flag; // RULE_12
    if (i_flags_clear) begin
      next_time_out = 1'h0;
      next_sleep = 1'h0;
    end
    // set wins when a kick meets a clear in the same cycle
    if (do_kick) begin
      next_time_out = 1'h1; // RULE_06
      next_sleep = 1'h1; // RULE_06
    end
  end

  // watchdog counter and its prescaler count on ticks; a kick overrides
  always @* begin
    next_watchdog = o_watchdog_counter;
    next_prescaler = o_prescaler;
    if (i_watchdog_tick) begin
      next_watchdog = o_watchdog_counter + {{(WDT_W-1){1'h0}}, 1'h1};
    end
    if (i_prescale_tick) begin
      next_prescaler = o_prescaler + {{(PRESC_W-1){1'h0}}, 1'h1};
    end
    if (do_kick) begin
      next_watchdog = `WDT_RESET_VAL; // RULE_04
      next_prescaler = `PRESC_RESET_VAL; // RULE_05
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      o_program_counter <= `PC_RESET_VAL;
      o_accumulator <= `ACC_RESET_VAL;
      o_zero_flag <= `ZERO_RESET_VAL;
      o_time_out_flag <= `TO_RESET_VAL;
      o_sleep_flag <= `SLEEP_RESET_VAL;
      o_watchdog_counter <= `WDT_RESET_VAL;
      o_prescaler <= `PRESC_RESET_VAL;
    end else begin
      state <= next_state;
      o_program_counter <= next_pc;
      o_accumulator <= next_acc;
      o_zero_flag <= next_zero;
      o_time_out_flag <= next_time_out;
      o_sleep_flag <= next_sleep;
      o_watchdog_counter <= next_watchdog;
      o_prescaler <= next_prescaler;
    end
  end

  // one-cycle pulses with the stack and file-register write ports
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_op_done <= 1'h0;
      o_stack_push <= 1'h0;
      o_stack_top_entry <= `PC_RESET_VAL;
      o_file_we <= 1'h0;
      o_file_waddr <= {AW{1'h0}};
      o_file_wdata <= {DW{1'h0}};
    end else begin
      // a call reports done from its second cycle
      o_op_done <= (take && !do_call) || (state == ST_CALL2); // RULE_01 RULE_12
      o_stack_push <= do_call; // RULE_01
      if (do_call) begin
        o_stack_top_entry <= pc_plus_one; // RULE_01
      end
      o_file_we <= file_write; // RULE_07 RULE_08 RULE_10
      if (file_write) begin
        o_file_waddr <= i_file_addr;
        o_file_wdata <= file_value; // RULE_07 RULE_08 RULE_10
      end
    end
  end
endmodule // core_ops

/* File: core_ops_defs.vh */
// constants for the call, clear, complement and decrement execution block
`ifndef CORE_OPS_DEFS_VH
`define CORE_OPS_DEFS_VH
`define OP_CALL 3'h1
`define OP_KICK 3'h2
`define OP_FZERO 3'h3
`define OP_AZERO 3'h4
`define OP_INV 3'h5
`define OP_DEC 3'h6
`define PC_W 13
`define PC_LO_W 11
`define LATCH_HI_POS 4
`define LATCH_LO_POS 3
`define WDT_RESET_VAL 8'h00
`define PRESC_RESET_VAL 8'h00
`define ACC_RESET_VAL 8'h00
`define PC_RESET_VAL 13'h0000
`define CALL_CYCLES 2'h2
`define PC_STEP 13'h0001
`define ZERO_RESET_VAL 1'h0
`define TO_RESET_VAL 1'h1
`define SLEEP_RESET_VAL 1'h1
`endif

/* File: core_ops_monitor.sv */
// assertions on the ports of the core_ops execution block
`timescale 1ns/1ns
`include "core_ops_defs.vh"
module core_ops_monitor (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_op_valid,
  input wire i_dest_file,
  input wire i_flags_clear,
  input wire [2:0] i_op_code,
  input wire [10:0] i_call_target,
  input wire [7:0] i_file_rdata,
  input wire [7:0] i_pc_high_latch,
  input wire o_op_ready,
  input wire o_op_done,
  input wire o_stack_push,
  input wire o_file_we,
  input wire o_zero_flag,
  input wire o_time_out_flag,
  input wire o_sleep_flag,
  input wire [12:0] o_program_counter,
  input wire [12:0] o_stack_top_entry,
  input wire [7:0] o_file_wdata,
  input wire [7:0] o_accumulator,
  input wire [7:0] o_watchdog_counter,
  input wire [7:0] o_prescaler
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire tk = i_op_valid & o_op_ready;
  wire [12:0] tgt = {i_pc_high_latch[4:3], i_call_target};
  wire [7:0] inv = ~i_file_rdata;
  wire [7:0] dec = i_file_rdata - 8'h01;
  wire [7:0] res = o_file_we ? o_file_wdata : o_accumulator;
  chk_call_push: assert property (tk && i_op_code == `OP_CALL |=> o_stack_push
    && o_stack_top_entry == $past(o_program_counter) + 13'h1) else $error("push wrong");
  chk_call_pc: assert property (tk && i_op_code == `OP_CALL |=>
    o_program_counter == $past(tgt)) else $error("call pc wrong");
  chk_call_len: assert property (tk && i_op_code == `OP_CALL |=>
    !o_op_ready && !o_op_done ##1 o_op_done) else $error("call length wrong");
  chk_kick_all: assert property (tk && i_op_code == `OP_KICK |=>
    !o_watchdog_counter && !o_prescaler && o_time_out_flag && o_sleep_flag) else $error("kick");
  chk_file_zero: assert property (tk && i_op_code == `OP_FZERO |=>
    o_file_we && o_file_wdata == 8'h00 && o_zero_flag) else $error("file clear wrong");
  chk_acc_zero: assert property (tk && i_op_code == `OP_AZERO |=>
    o_accumulator == 8'h00 && o_zero_flag) else $error("acc clear wrong");
  chk_inv_res: assert property (tk && i_op_code == `OP_INV |=>
    o_file_we == $past(i_dest_file) && res == $past(inv) && o_zero_flag == !res) else $error("inv");
  chk_dec_res: assert property (tk && i_op_code == `OP_DEC |=>
    o_file_we == $past(i_dest_file) && res == $past(dec) && o_zero_flag == !res) else $error("dec");
  chk_flags_keep: assert property (tk && !i_flags_clear && i_op_code > `OP_KICK
    && i_op_code < 3'h7 |=> o_op_done && $stable(o_time_out_flag) && $stable(o_sleep_flag))
    else $error("flags or done wrong");
  cover property (tk && i_op_code == `OP_CALL);
  cover property (tk && i_op_code == `OP_KICK);
  cover property (tk && i_op_code == `OP_DEC && i_dest_file);
endmodule // core_ops_monitor

/* File: core_ops_tb_top.sv */
// self-checking testbench for the core_ops execution block
`timescale 1ns/1ns
`include "core_ops_defs.vh"
module core_ops_tb_top;
  reg i_clk = 1'h0, i_sys_rst = 1'h1, i_op_valid = 1'h0, i_dest_file = 1'h0;
  reg i_flags_clear = 1'h0, i_watchdog_tick = 1'h0, i_prescale_tick = 1'h0;
  reg [2:0] i_op_code = 3'h0;
  reg [10:0] i_call_target;
  reg [6:0] i_file_addr;
  reg [7:0] i_file_rdata = 8'h00, i_pc_high_latch, r, e;
  reg [12:0] p;
  wire o_op_ready, o_op_done, o_stack_push, o_file_we, o_zero_flag, o_time_out_flag, o_sleep_flag;
  wire [12:0] o_program_counter, o_stack_top_entry;
  wire [6:0] o_file_waddr;
  wire [7:0] o_file_wdata, o_accumulator, o_watchdog_counter, o_prescaler;
  integer err_total = 0, n_checks = 0, i;
  core_ops dut_u (.*);
  always #2 i_clk = ~i_clk;
  task cmp(input [63:0] nm, input [12:0] x, y);
    n_checks = n_checks + 1;
    if (y !== x) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %0s exp %h got %h", nm, x, y);
    end
  endtask
  task op(input [2:0] k, input dd, input [7:0] rd);
    @(posedge i_clk);
    {i_op_valid, i_op_code, i_dest_file, i_file_rdata} <= {1'h1, k, dd, rd};
    @(posedge i_clk);
    i_op_valid <= 1'h0;
    #1;
  endtask
  task t_call;
    p = o_program_counter;
    op(`OP_CALL, 1'h0, 8'h00);
    cmp("pc", 13'h1FFF, o_program_counter);
    cmp("push", 1'h1, o_stack_push);
    cmp("top", p + 13'h1, o_stack_top_entry);
    cmp("ready", 1'h0, o_op_ready);
    @(posedge i_clk);
    #1 cmp("done", 1'h1, o_op_done);
    $display("call test ended");
  endtask
  task t_kick;
    @(posedge i_clk);
    {i_watchdog_tick, i_prescale_tick, i_flags_clear} <= 3'h7;
    repeat (3) @(posedge i_clk);
    {i_watchdog_tick, i_prescale_tick, i_flags_clear} <= 3'h0;
    #1 cmp("to", 1'h0, o_time_out_flag);
    cmp("sleep", 1'h0, o_sleep_flag);
    cmp("wdt", 13'h3, o_watchdog_counter);
    cmp("presc", 13'h3, o_prescaler);
    op(`OP_KICK, 1'h0, 8'h00);
    cmp("wdt", 13'h0, o_watchdog_counter);
    cmp("presc", 13'h0, o_prescaler);
    cmp("to", 1'h1, o_time_out_flag);
    cmp("sleep", 1'h1, o_sleep_flag);
    $display("kick test ended");
  endtask
  task t_alu;
    for (i = 0; i < 4; i = i + 1) begin
      r = i[1] ? {7'h00, !i[0]} : (i[0] ? 8'h5A : 8'hFF);
      e = i[1] ? r - 8'h01 : ~r;
      op(i[1] ? `OP_DEC : `OP_INV, !i[0], r);
      cmp("we", !i[0], o_file_we);
      cmp("res", e, i[0] ? o_accumulator : o_file_wdata);
      cmp("z", e == 8'h00, o_zero_flag);
      cmp("to", 1'h1, o_time_out_flag);
    end
    $display("invert and decrement test ended");
  endtask
  task t_clr;
    op(`OP_AZERO, 1'h0, 8'h00);
    cmp("acc", 8'h00, o_accumulator);
    cmp("z", 1'h1, o_zero_flag);
    op(`OP_INV, 1'h1, 8'h0F);
    @(posedge i_clk);
    i_file_addr <= 7'h2C;
    op(`OP_FZERO, 1'h0, 8'h5A);
    cmp("addr", 7'h2C, o_file_waddr);
    cmp("wdata", 13'h100, {o_file_we, o_file_wdata});
    cmp("z", 1'h1, o_zero_flag);
    $display("clear test ended");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {i_call_target, i_pc_high_latch, i_file_addr} <= {11'h7FF, 8'h18, 7'h7F};
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    t_call;
    t_kick;
    t_alu;
    t_clr;
    stop_test;
  end
  initial #20000 begin
    err_total = err_total + 1;
    stop_test;
  end
endmodule // core_ops_tb_top
bind core_ops core_ops_monitor mon_u (.*);

/* File: result_unit.v */
// data path: complement or decrement of an operand, with zero detect
`timescale 1ns/1ns
module result_unit #(
  parameter W = 8
) (
  input wire [W-1:0] i_operand,
  input wire i_decrement,
  output wire [W-1:0] o_result,
  output wire o_is_zero
);
  assign o_result = i_decrement ? (i_operand - {{(W-1){1'b0}}, 1'b1}) : ~i_operand;
  assign o_is_zero = (o_result == {W{1'b0}});
endmodule // result_unit
